/* File: sgc_pkg.sv */
// Package with register layout, reset values and management frame constants.
package sgc_pkg;

  localparam logic [4:0] CTRL_REGAD     = 5'h00;
  localparam logic [4:0] BCAST_PHYAD    = 5'h00;

  localparam int         BIT_RESET      = 15;
  localparam int         BIT_RSVD14     = 14;
  localparam int         BIT_SPEED_LSB  = 13;
  localparam int         BIT_AN_EN      = 12;
  localparam int         BIT_PWR_DN     = 11;
  localparam int         BIT_ISOLATE    = 10;
  localparam int         BIT_AN_RESTART = 9;
  localparam int         BIT_DUPLEX     = 8;
  localparam int         BIT_COL_TEST   = 7;
  localparam int         BIT_SPEED_MSB  = 6;
  localparam int         BIT_UNIDIR     = 5;
  localparam int         LOW_FIELD_MSB  = 4;

  localparam logic       RST_RESET      = 1'b0;
  localparam logic       RST_RSVD14     = 1'b0;
  localparam logic       RST_AN_EN      = 1'b1;
  localparam logic       RST_BIT11      = 1'b0;
  localparam logic       RST_ISOLATE    = 1'b1;
  localparam logic       RST_AN_RESTART = 1'b0;
  localparam logic       RST_UNIDIR     = 1'b0;

  localparam logic       VAL_SPEED_LSB  = 1'b0;
  localparam logic       VAL_SPEED_MSB  = 1'b1;
  localparam logic       VAL_DUPLEX     = 1'b1;
  localparam logic       VAL_COL_TEST   = 1'b0;
  localparam logic [4:0] VAL_LOW_FIELD  = 5'h00;

  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [3:0] HDR_LAST       = 4'hB;
  localparam logic [3:0] TA_LAST        = 4'h1;
  localparam logic [3:0] DATA_LAST      = 4'hF;
  localparam int         STALL_CYCLES   = 2000;

  typedef enum logic [2:0] {
    SGC_IDLE  = 3'h0,
    SGC_START = 3'h1,
    SGC_HDR   = 3'h2,
    SGC_WTA   = 3'h3,
    SGC_WDATA = 3'h4,
    SGC_RTA   = 3'h5,
    SGC_RDATA = 3'h6
  } sgc_mdio_state_t;

endpackage : sgc_pkg

/* File: sgc_ctrl_reg.sv */
// Control register of one serial channel with its self-clearing requests.
module sgc_ctrl_reg #(
  parameter bit HAS_POWER_DOWN = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             module_reset_req,
  input  wire logic        module_reset_ack,
  output logic             autoneg_restart_req,
  input  wire logic        autoneg_restart_ack,
  output logic             autoneg_enable,
  output logic             power_down,
  output logic             isolate,
  output logic             unidir_tx_enable
);

  logic reset_pend;
  logic rsvd14;
  logic an_en;
  logic bit11;
  logic iso;
  logic restart_pend;
  logic unidir;
  logic take_reset;

  // The module reset is taken when the controlled logic acknowledges it.
  assign take_reset = module_reset_ack & reset_pend;

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_pend <= sgc_pkg::RST_RESET;
    end else if (wr_en && wdata[sgc_pkg::BIT_RESET]) begin
      reset_pend <= 1'b1;
    end else if (take_reset) begin
      reset_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || take_reset) begin
      rsvd14 <= sgc_pkg::RST_RSVD14;
      an_en  <= sgc_pkg::RST_AN_EN;
      bit11  <= sgc_pkg::RST_BIT11;
      iso    <= sgc_pkg::RST_ISOLATE;
      unidir <= sgc_pkg::RST_UNIDIR;
    end else if (wr_en) begin
      rsvd14 <= wdata[sgc_pkg::BIT_RSVD14];
      an_en  <= wdata[sgc_pkg::BIT_AN_EN];
      iso    <= wdata[sgc_pkg::BIT_ISOLATE];
      unidir <= wdata[sgc_pkg::BIT_UNIDIR];
      if (HAS_POWER_DOWN) begin
        bit11 <= bit11 | wdata[sgc_pkg::BIT_PWR_DN];
      end else begin
        bit11 <= wdata[sgc_pkg::BIT_PWR_DN];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || take_reset) begin
      restart_pend <= sgc_pkg::RST_AN_RESTART;
    end else if (wr_en && wdata[sgc_pkg::BIT_AN_RESTART]) begin
      restart_pend <= 1'b1;
    end else if (autoneg_restart_ack) begin
      restart_pend <= 1'b0;
    end
  end

  always_comb begin
    rdata                              = 16'h0000;
    rdata[sgc_pkg::BIT_RESET]          = reset_pend;
    rdata[sgc_pkg::BIT_RSVD14]         = rsvd14;
    rdata[sgc_pkg::BIT_SPEED_LSB]      = sgc_pkg::VAL_SPEED_LSB;
    rdata[sgc_pkg::BIT_AN_EN]          = an_en;
    rdata[sgc_pkg::BIT_PWR_DN]         = bit11;
    rdata[sgc_pkg::BIT_ISOLATE]        = iso;
    rdata[sgc_pkg::BIT_AN_RESTART]     = restart_pend;
    rdata[sgc_pkg::BIT_DUPLEX]         = sgc_pkg::VAL_DUPLEX;
    rdata[sgc_pkg::BIT_COL_TEST]       = sgc_pkg::VAL_COL_TEST;
    rdata[sgc_pkg::BIT_SPEED_MSB]      = sgc_pkg::VAL_SPEED_MSB;
    rdata[sgc_pkg::BIT_UNIDIR]         = unidir;
    rdata[sgc_pkg::LOW_FIELD_MSB:0]    = sgc_pkg::VAL_LOW_FIELD;
  end

  assign module_reset_req    = reset_pend;
  assign autoneg_restart_req = restart_pend;
  assign autoneg_enable      = an_en;
  assign isolate             = iso;
  assign power_down          = HAS_POWER_DOWN ? bit11 : 1'b0;
  assign unidir_tx_enable    = unidir & ~an_en;

endmodule : sgc_ctrl_reg

/* File: sgc_control.sv */
// Per-channel management serial slaves, each holding its own control register.
module sgc_control #(
  parameter int NUM_CH      = 4,
  parameter int STALL_LIMIT = sgc_pkg::STALL_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [NUM_CH*5-1:0] phyad,
  input  wire logic [NUM_CH-1:0]   mdc,
  input  wire logic [NUM_CH-1:0]   mdio_in,
  output logic      [NUM_CH-1:0]   mdio_out,
  output logic      [NUM_CH-1:0]   mdio_tri,
  output logic      [NUM_CH-1:0]   module_reset_req,
  input  wire logic [NUM_CH-1:0]   module_reset_ack,
  output logic      [NUM_CH-1:0]   autoneg_restart_req,
  input  wire logic [NUM_CH-1:0]   autoneg_restart_ack,
  output logic      [NUM_CH-1:0]   autoneg_enable,
  output logic      [NUM_CH-1:0]   power_down,
  output logic      [NUM_CH-1:0]   isolate,
  output logic      [NUM_CH-1:0]   unidir_tx_enable
);

  if (NUM_CH < 1 || NUM_CH > 31) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 31.");
  end

  if (STALL_LIMIT < 16 || STALL_LIMIT > 4095) begin : g_bad_stall
    $error("STALL_LIMIT must lie between 16 and 4095.");
  end

  // A frame is ours when it names our address or the broadcast address.
  function automatic logic sgc_addressed(input logic [4:0] frame_ad, input logic [4:0] own_ad);
    sgc_addressed = (frame_ad == own_ad) || (frame_ad == sgc_pkg::BCAST_PHYAD);
  endfunction : sgc_addressed

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [2:0]               mdc_sync;
    logic [1:0]               mdio_sync;
    logic                     mdc_rise;
    logic                     mdc_fall;
    logic                     bit_in;
    sgc_pkg::sgc_mdio_state_t state;
    sgc_pkg::sgc_mdio_state_t next_state;
    logic [3:0]               cnt;
    logic [11:0]              hdr;
    logic [11:0]              next_hdr;
    logic                     hit;
    logic                     is_write;
    logic [15:0]              wshift;
    logic [15:0]              rshift;
    logic [15:0]              reg_rdata;
    logic                     reg_wr;
    logic                     out_bit;
    logic                     tri_bit;
    logic [4:0]               ad_meta;
    logic [4:0]               own_ad;
    logic [11:0]              stall_cnt;
    logic                     stall_hit;

    // The first stage of each synchroniser feeds only the second stage.
    always_ff @(posedge clk) begin
      if (rst) begin
        mdc_sync  <= 3'h0;
        mdio_sync <= 2'h3;
        ad_meta   <= 5'h00;
        own_ad    <= 5'h00;
      end else begin
        mdc_sync  <= {mdc_sync[1:0], mdc[ch]};
        mdio_sync <= {mdio_sync[0], mdio_in[ch]};
        ad_meta   <= phyad[ch*5 +: 5];
        own_ad    <= ad_meta;
      end
    end

    assign mdc_rise = mdc_sync[1] & ~mdc_sync[2];
    assign mdc_fall = ~mdc_sync[1] & mdc_sync[2];
    assign bit_in   = mdio_sync[1];
    assign next_hdr = {hdr[10:0], bit_in};

    // A frame cut short by a stopped management clock is dropped and the line released.
    // A station must therefore not pause the clock inside a frame for STALL_LIMIT cycles.
    always_ff @(posedge clk) begin
      if (rst || stall_hit || mdc_rise || mdc_fall ||
          (state == sgc_pkg::SGC_IDLE && tri_bit)) begin
        stall_cnt <= 12'h000;
      end else begin
        stall_cnt <= stall_cnt + 12'h001;
      end
    end

    assign stall_hit = (stall_cnt == 12'(STALL_LIMIT));

    always_comb begin
      next_state = state;
      case (state)
        sgc_pkg::SGC_IDLE:  next_state = bit_in ? sgc_pkg::SGC_IDLE : sgc_pkg::SGC_START;
        sgc_pkg::SGC_START: next_state = bit_in ? sgc_pkg::SGC_HDR : sgc_pkg::SGC_IDLE;
        sgc_pkg::SGC_HDR: begin
          if (cnt == sgc_pkg::HDR_LAST) begin
            if (sgc_addressed(next_hdr[9:5], own_ad) &&
                next_hdr[11:10] == sgc_pkg::OP_READ) begin
              next_state = sgc_pkg::SGC_RTA;
            end else begin
              next_state = sgc_pkg::SGC_WTA;
            end
          end
        end
        sgc_pkg::SGC_WTA:   next_state = (cnt == sgc_pkg::TA_LAST) ? sgc_pkg::SGC_WDATA : state;
        sgc_pkg::SGC_RTA:   next_state = (cnt == sgc_pkg::TA_LAST) ? sgc_pkg::SGC_RDATA : state;
        sgc_pkg::SGC_WDATA: next_state = (cnt == sgc_pkg::DATA_LAST) ? sgc_pkg::SGC_IDLE : state;
        sgc_pkg::SGC_RDATA: next_state = (cnt == sgc_pkg::DATA_LAST) ? sgc_pkg::SGC_IDLE : state;
        default:            next_state = sgc_pkg::SGC_IDLE;
      endcase
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        state <= sgc_pkg::SGC_IDLE;
        cnt   <= 4'h0;
      end else if (stall_hit) begin
        state <= sgc_pkg::SGC_IDLE;
        cnt   <= 4'h0;
      end else if (mdc_rise) begin
        state <= next_state;
        cnt   <= (next_state != state) ? 4'h0 : cnt + 4'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        hdr      <= 12'h000;
        hit      <= 1'b0;
        is_write <= 1'b0;
        rshift   <= 16'h0000;
      end else if (mdc_rise && state == sgc_pkg::SGC_HDR) begin
        hdr <= next_hdr;
        if (cnt == sgc_pkg::HDR_LAST) begin
          hit      <= sgc_addressed(next_hdr[9:5], own_ad) &&
                      next_hdr[4:0] == sgc_pkg::CTRL_REGAD;
          is_write <= next_hdr[11:10] == sgc_pkg::OP_WRITE;
          rshift   <= (next_hdr[4:0] == sgc_pkg::CTRL_REGAD) ? reg_rdata : 16'h0000;
        end
      end else if (mdc_rise && state == sgc_pkg::SGC_RDATA) begin
        rshift <= {rshift[14:0], 1'b0};
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        wshift <= 16'h0000;
        reg_wr <= 1'b0;
      end else begin
        reg_wr <= 1'b0;
        if (mdc_rise && state == sgc_pkg::SGC_WDATA) begin
          wshift <= {wshift[14:0], bit_in};
          reg_wr <= (cnt == sgc_pkg::DATA_LAST) && hit && is_write;
        end
      end
    end

    // The slave drives the line only on falling clock edges, low for the last turnaround bit, then the register bits.
    always_ff @(posedge clk) begin
      if (rst) begin
        out_bit <= 1'b1;
        tri_bit <= 1'b1;
      end else if (stall_hit) begin
        out_bit <= 1'b1;
        tri_bit <= 1'b1;
      end else if (mdc_fall) begin
        if (state == sgc_pkg::SGC_RTA && cnt == sgc_pkg::TA_LAST) begin
          out_bit <= 1'b0;
          tri_bit <= 1'b0;
        end else if (state == sgc_pkg::SGC_RDATA) begin
          out_bit <= rshift[15];
          tri_bit <= 1'b0;
        end else begin
          out_bit <= 1'b1;
          tri_bit <= 1'b1;
        end
      end
    end

    assign mdio_out[ch] = out_bit;
    assign mdio_tri[ch] = tri_bit;

    sgc_ctrl_reg #(
      .HAS_POWER_DOWN (ch == 0)
    ) u_reg (
      .clk                 (clk),
      .rst                 (rst),
      .wr_en               (reg_wr),
      .wdata               (wshift),
      .rdata               (reg_rdata),
      .module_reset_req    (module_reset_req[ch]),
      .module_reset_ack    (module_reset_ack[ch]),
      .autoneg_restart_req (autoneg_restart_req[ch]),
      .autoneg_restart_ack (autoneg_restart_ack[ch]),
      .autoneg_enable      (autoneg_enable[ch]),
      .power_down          (power_down[ch]),
      .isolate             (isolate[ch]),
      .unidir_tx_enable    (unidir_tx_enable[ch])
    );
  end

endmodule : sgc_control

/* File: sgc_control_chk.sv */
// Checker for the control register outputs of each channel and for the serial line timing of channel 0.
module sgc_control_chk #(
  parameter int NUM_CH = 4
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [NUM_CH-1:0] mdc,
  input wire logic [NUM_CH-1:0] mdio_out,
  input wire logic [NUM_CH-1:0] mdio_tri,
  input wire logic [NUM_CH-1:0] module_reset_req,
  input wire logic [NUM_CH-1:0] module_reset_ack,
  input wire logic [NUM_CH-1:0] autoneg_restart_req,
  input wire logic [NUM_CH-1:0] autoneg_restart_ack,
  input wire logic [NUM_CH-1:0] autoneg_enable,
  input wire logic [NUM_CH-1:0] power_down,
  input wire logic [NUM_CH-1:0] isolate,
  input wire logic [NUM_CH-1:0] unidir_tx_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_CH-1:0] mr_wait;
  logic [NUM_CH-1:0] ar_wait;
  logic [NUM_CH-1:0] mr_take;
  logic [NUM_CH-1:0] ar_take;
  assign mr_wait = module_reset_req & ~module_reset_ack;
  assign ar_wait = autoneg_restart_req & ~autoneg_restart_ack;
  assign mr_take = module_reset_req & module_reset_ack;
  assign ar_take = autoneg_restart_req & autoneg_restart_ack;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  reset_state_a:
    assert property ($fell(rst) |-> autoneg_enable == '1 && isolate == '1 && power_down == '0
      && unidir_tx_enable == '0 && module_reset_req == '0 && mdio_tri == '1)
    else $error("Outputs not at defaults after reset.");
  unidir_gate_a:
    assert property ((unidir_tx_enable & autoneg_enable) == '0)
    else $error("Unidirectional transmit while negotiation enabled.");
  no_power_down_a:
    assert property (power_down[NUM_CH-1:1] == '0)
    else $error("Power down seen on a later channel.");
  power_sticky_a:
    assert property ($fell(power_down[0]) |-> $past(mr_take[0]) || $past(mr_take[0], 2))
    else $error("Power down cleared without a module reset.");
  reset_hold_a:
    assert property (($past(mr_wait) & ~module_reset_req) == '0)
    else $error("Module reset request dropped before acceptance.");
  restart_hold_a:
    assert property (($past(ar_wait) & ~autoneg_restart_req) == '0)
    else $error("Restart request dropped before acceptance.");
  reset_clear_a:
    assert property (($past(mr_take) & module_reset_req) == '0)
    else $error("Module reset request stayed after acceptance.");
  restart_clear_a:
    assert property (($past(ar_take) & autoneg_restart_req) == '0)
    else $error("Restart request stayed after acceptance.");
  line_edge_a:
    assert property ($changed(mdio_out[0]) && !mdio_tri[0] |-> !mdc[0])
    else $error("Driven data changed while the management clock was high.");
  cover property (mr_take[0]);
  cover property ($fell(power_down[0]));
  cover property (!mdio_tri[1]);
  cover property (ar_take[1]);
endmodule : sgc_control_chk

/* File: sgc_sta_model.sv */
// Management station model that frames reads and writes on the serial line.
module sgc_sta_model (
  input  wire logic clk,
  input  wire logic mdio_line,
  output logic      mdc,
  output logic      sta_o,
  output logic      sta_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int stop_at = -1;
  initial begin
    mdc    = 1'b0;
    sta_o  = 1'b1;
    sta_oe = 1'b0;
  end
  // The line is released for turnaround and data of a read; the pull-up holds it high wherever the slave does not drive it.
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [35:0] bits;
    bits = {4'hF, 2'h1, op, phy, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 35; i > stop_at; i--) begin
      @(posedge clk);
      sta_oe <= !(op == sgc_pkg::OP_READ && i < 18);
      sta_o  <= bits[i];
      repeat (5) @(posedge clk);
      rd = {rd[14:0], mdio_line};
      mdc <= 1'b1;
      repeat (5) @(posedge clk);
      mdc <= 1'b0;
    end
    sta_oe <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : xfer
endmodule : sgc_sta_model

/* File: testbench.sv */
// Self-checking bench for the control registers of two channels.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 2;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           ack_en = 1'b0;
  logic           sta_mdc;
  logic           sta_o;
  logic           sta_oe;
  logic           line;
  logic [NCH-1:0] mr_req;
  logic [NCH-1:0] mr_ack = '0;
  logic [NCH-1:0] ar_req;
  logic [NCH-1:0] ar_ack = '0;
  logic [NCH-1:0] an_en;
  logic [NCH-1:0] pd;
  logic [NCH-1:0] iso;
  logic [NCH-1:0] uni;
  logic [NCH-1:0] m_out;
  logic [NCH-1:0] m_tri;
  logic [15:0]    rd;
  int             n_tests = 0;
  int             n_mismatch = 0;
  int             cyc = 0;
  assign line = (sta_oe ? sta_o : 1'b1) & (&(m_tri | m_out));
  always #20 clk = ~clk;
  sgc_control #(.NUM_CH(NCH)) dut_u (.clk(clk), .rst(rst),
    .phyad({5'h2, 5'h1}), .mdc({NCH{sta_mdc}}), .mdio_in({NCH{line}}), .mdio_out(m_out),
    .mdio_tri(m_tri), .module_reset_req(mr_req), .module_reset_ack(mr_ack),
    .autoneg_restart_req(ar_req), .autoneg_restart_ack(ar_ack), .autoneg_enable(an_en),
    .power_down(pd), .isolate(iso), .unidir_tx_enable(uni));
  sgc_sta_model sta_u (.clk(clk), .mdio_line(line), .mdc(sta_mdc), .sta_o(sta_o),
    .sta_oe(sta_oe));
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    mr_ack <= ack_en ? mr_req : '0;
    ar_ack <= ack_en ? ar_req : '0;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input int ch, input logic [15:0] d);
    sta_u.xfer(sgc_pkg::OP_WRITE, 5'(ch + 1), sgc_pkg::CTRL_REGAD, d, rd);
  endtask : wr
  task automatic rd_chk(input int ch, input logic [15:0] exp);
    sta_u.xfer(sgc_pkg::OP_READ, 5'(ch + 1), sgc_pkg::CTRL_REGAD, 16'h0000, rd);
    chk("control", rd, exp);
  endtask : rd_chk
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(0, 16'h1540);
    rd_chk(1, 16'h1540);
    ack_en <= 1'b1;
    wr(0, 16'h7DFF);
    rd_chk(0, 16'h5D60);
    wr(0, 16'h0020);
    rd_chk(0, 16'h0960);
    chk("ch0 outs", {12'h000, an_en[0], pd[0], iso[0], uni[0]}, 16'h0005);
    wr(1, 16'h7DFF);
    rd_chk(1, 16'h5D60);
    chk("ch1 pd", {15'h0000, pd[1]}, 16'h0000);
    wr(1, 16'h1020);
    rd_chk(1, 16'h1160);
    chk("ch1 uni", {14'h0000, uni[1], an_en[1]}, 16'h0001);
    rd_chk(0, 16'h0960);
    ack_en <= 1'b0;
    wr(0, 16'h8000);
    chk("reset req", {14'h0000, ar_req[0], mr_req[0]}, 16'h0001);
    ack_en <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset done", {14'h0000, mr_req}, 16'h0000);
    rd_chk(0, 16'h1540);
    rd_chk(1, 16'h1160);
    ack_en <= 1'b0;
    wr(1, 16'h1200);
    chk("restart req", {14'h0000, ar_req}, 16'h0002);
    ack_en <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(1, 16'h1140);
    sta_u.xfer(sgc_pkg::OP_WRITE, 5'h1, 5'h1, 16'h0000, rd);
    sta_u.xfer(sgc_pkg::OP_WRITE, 5'h5, sgc_pkg::CTRL_REGAD, 16'h0000, rd);
    sta_u.xfer(sgc_pkg::OP_READ, 5'h1, 5'h1, 16'h0000, rd);
    chk("other reg", rd, 16'h0000);
    rd_chk(0, 16'h1540);
    sta_u.stop_at = 10;
    sta_u.xfer(sgc_pkg::OP_READ, 5'h1, sgc_pkg::CTRL_REGAD, 16'h0000, rd);
    sta_u.stop_at = -1;
    chk("cut drive", {15'h0000, m_tri[0]}, 16'h0000);
    repeat (sgc_pkg::STALL_CYCLES + 10) @(posedge clk);
    chk("cut release", {15'h0000, m_tri[0]}, 16'h0001);
    rd_chk(0, 16'h1540);
    summarize();
  end
endmodule : testbench
bind sgc_control sgc_control_chk #(.NUM_CH(NUM_CH)) chk_u (.clk(clk), .rst(rst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_tri(mdio_tri), .module_reset_req(module_reset_req),
  .module_reset_ack(module_reset_ack), .autoneg_restart_req(autoneg_restart_req),
  .autoneg_restart_ack(autoneg_restart_ack), .autoneg_enable(autoneg_enable),
  .power_down(power_down), .isolate(isolate), .unidir_tx_enable(unidir_tx_enable));
